/* File: hw/rbc_pkg.sv */
package rbc_pkg;
	localparam int CLK_MHZ = 40;
	// pll settling, internal init and core reset durations
	localparam int PLL_LOCK_NS = 1000;
	localparam int PLL_LOCK_CYC = (PLL_LOCK_NS * CLK_MHZ + 999) / 1000;
	localparam int INIT_NS = 2000;
	localparam int INIT_CYC = (INIT_NS * CLK_MHZ + 999) / 1000;
	localparam int CORE_RST_NS = 100;
	localparam int CORE_RST_CYC = (CORE_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 12;
	localparam int LINK_DIV_W = 8;
	localparam logic [LINK_DIV_W-1:0] LINK_DIV_MIN = 8'h0C;
	localparam logic [LINK_DIV_W-1:0] LINK_DIV_RESET = 8'h10;

	localparam logic [2:0] RATIO_DEFAULT = 3'h0;
	localparam logic [2:0] RATIO_RESERVED = 3'h7;
	localparam logic [3:0] MULT_4 = 4'h4;
	localparam logic [3:0] MULT_5 = 4'h5;
	localparam logic [3:0] MULT_6 = 4'h6;
	localparam logic [3:0] MULT_7 = 4'h7;
	localparam logic [3:0] MULT_8 = 4'h8;
	localparam logic [3:0] MULT_10 = 4'hA;
	localparam logic [3:0] MULT_12 = 4'hC;

	localparam logic [31:0] RUN_ADDR_IRQ0 = 32'h3000_0000;
	localparam logic [31:0] RUN_ADDR_IRQ1 = 32'h3800_0000;
	localparam logic [31:0] RUN_ADDR_IRQ2 = 32'h8000_0000;
	localparam logic [31:0] RUN_ADDR_IRQ3 = 32'h0000_0000;
	// irq lines enabled by reset so that they can wake the idle core
	localparam logic [3:0] IRQ_EN_RESET = 4'hF;

	typedef enum logic [1:0] {
		BOOT_MEMORY = 2'h0,
		BOOT_HOST = 2'h1,
		BOOT_LINK = 2'h2,
		BOOT_NONE = 2'h3
	} rbc_boot_t;

	typedef enum logic [2:0] {
		S_HOLD = 3'h0,
		S_PLL = 3'h1,
		S_INIT = 3'h3,
		S_IDLE = 3'h2,
		S_RUN = 3'h6,
		S_CORE_RST = 3'h7
	} rbc_state_t;
endpackage

/* File: hw/rbc_clk_if.sv */
`timescale 1ns/100ps
interface rbc_clk_if;
	import rbc_pkg::*;
	logic [2:0] ratioStraps;
	logic trackStraps;
	logic [LINK_DIV_W-1:0] linkDivisor;
	logic [3:0] pllMult;
	logic ratioBad;
	logic linkClk;
	logic [3:0] busTicks;
	modport gen (
		input ratioStraps, trackStraps, linkDivisor,
		output pllMult, ratioBad, linkClk, busTicks
	);
	modport seq (
		output ratioStraps, trackStraps, linkDivisor,
		input pllMult, ratioBad, linkClk, busTicks
	);
endinterface

/* File: hw/rbc_clk_gen.sv */
`timescale 1ns/100ps
module rbc_clk_gen (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	rbc_clk_if.gen cif
);
	import rbc_pkg::*;

	typedef struct packed {
		logic [2:0] strap;
		logic [3:0] mult;
		logic bad;
		logic [LINK_DIV_W:0] linkAcc;
		logic linkClk;
		logic busRem;
		logic [3:0] busTicks;
	} rbc_clk_state_t;

	rbc_clk_state_t st;
	rbc_clk_state_t next_st;

	function automatic logic [3:0] decodeRatio(input logic [2:0] code);
		case (code)
			3'h1: decodeRatio = MULT_5;
			3'h2: decodeRatio = MULT_6;
			3'h3: decodeRatio = MULT_7;
			3'h4: decodeRatio = MULT_8;
			3'h5: decodeRatio = MULT_10;
			3'h6: decodeRatio = MULT_12;
			default: decodeRatio = MULT_4;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	always_comb begin
		logic [LINK_DIV_W:0] div;
		logic [LINK_DIV_W:0] sum;
		logic [4:0] busSum;
		div = {1'b0, cif.linkDivisor};
		sum = '0;
		busSum = '0;
		next_st = st;
		// straps only followed while chip reset holds
		if (cif.trackStraps) begin
			next_st.strap = cif.ratioStraps;
			next_st.mult = decodeRatio(cif.ratioStraps); // [RL16] [RL10]
			next_st.bad = (cif.ratioStraps == RATIO_RESERVED); // [RL16]
		end
		// link clock: toggle every divisor core cycles (divisor raised to LINK_DIV_MIN if below), mult core cycles per sys tick
		if (cif.linkDivisor < LINK_DIV_MIN) begin
			div = {1'b0, LINK_DIV_MIN};
		end
		sum = st.linkAcc + {{(LINK_DIV_W-3){1'b0}}, st.mult};
		if (sum >= div) begin
			next_st.linkAcc = sum - div; // [RL11]
			next_st.linkClk = ~st.linkClk; // [RL11]
		end else begin
			next_st.linkAcc = sum;
		end
		// bus runs at half core rate: mult/2 bus cycles per sys cycle
		busSum = {1'b0, st.mult} + {4'h0, st.busRem};
		next_st.busTicks = busSum[4:1]; // [RL12] [RL13]
		next_st.busRem = busSum[0]; // [RL12]
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '{strap: RATIO_DEFAULT, mult: MULT_4, bad: 1'b0, linkAcc: '0,
				linkClk: 1'b0, busRem: 1'b0, busTicks: 4'h0};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign cif.pllMult = st.mult;
	assign cif.ratioBad = st.bad;
	assign cif.linkClk = st.linkClk;
	assign cif.busTicks = st.busTicks;
endmodule

/* File: hw/rbc_sequencer.sv */
// Overview of operation
// RL1: board pulls chip reset low after power-up
// RL2: later chip reset low resets all logic; link clock and bus tick state in rbc_clk_gen is reset only by rst
// RL3: soft reset bit resets core only
// RL4: board ties reset-done to DRAM power-on reset
// RL5: four boot modes: memory, host, link, none
// RL6: no-boot runs only after an interrupt line
// RL7: interrupt line picks the start fetch address
// RL8: core leaves reset idle until interrupt; memory, host and link boot leave idle on bootStart instead
// RL9: reset enables vectors for wake interrupts
// RL10: core clock is strap ratio times sys
// RL11: link clock is core over programmable divisor
// RL12: on-chip bus clock is half core clock
// RL13: buffer moves clocked at on-chip bus rate
// RL14: external bus interface runs on sys clock
// RL15: sys clock at most quarter core clock
// RL16: straps 000..110 give 4..12, 111 reserved
// RL17: straps change only during chip reset
// RL18: reset-done only after internal sequence completes
// RL19: async reset and irq lines synchronised first
`timescale 1ns/100ps
module rbc_sequencer #(
	parameter int LOCK_CYC = rbc_pkg::PLL_LOCK_CYC,
	parameter int INIT_CYCLES = rbc_pkg::INIT_CYC,
	parameter int CORE_CYC = rbc_pkg::CORE_RST_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic chipResetN,
	input wire logic [3:0] externalInterruptLinesN,
	input wire logic [2:0] coreRatioStraps,
	input wire logic [1:0] bootMode,
	input wire logic bootStart,
	input wire logic coreSoftResetBit,
	input wire logic [rbc_pkg::LINK_DIV_W-1:0] linkDivisor,
	output logic resetDone,
	output logic ioReset,
	output logic coreReset,
	output logic coreIdle,
	output logic [31:0] fetchAddr,
	output logic fetchValid,
	output logic [3:0] irqEnabled,
	output logic [3:0] pllMult,
	output logic ratioBad,
	output logic linkClk,
	output logic [3:0] busTicks,
	output logic extPortClkEn
);
	import rbc_pkg::*;

	// counts must fit the shared phase counter
	if (LOCK_CYC < 1 || LOCK_CYC >= (1 << CNT_W)) begin : gLockRange
		$error("LOCK_CYC out of range");
	end
	if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << CNT_W)) begin : gInitRange
		$error("INIT_CYCLES out of range");
	end
	if (CORE_CYC < 1 || CORE_CYC >= (1 << CNT_W)) begin : gCoreRange
		$error("CORE_CYC out of range");
	end

	localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYC - 1);
	localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);
	localparam logic [CNT_W-1:0] CORE_LAST = CNT_W'(CORE_CYC - 1);

	typedef struct packed {
		logic rstMeta;
		logic rstSync;
		logic [3:0] irqMeta;
		logic [3:0] irqSync;
		rbc_state_t state;
		logic [CNT_W-1:0] count;
		rbc_boot_t boot;
		logic resetDone;
		logic ioReset;
		logic coreReset;
		logic coreIdle;
		logic [31:0] fetchAddr;
		logic fetchValid;
		logic [3:0] irqEnabled;
		logic extPortClkEn;
	} rbc_seq_state_t;

	rbc_seq_state_t st;
	rbc_seq_state_t next_st;

	rbc_clk_if cif ();

	rbc_clk_gen u_clk_gen (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.cif(cif)
	);

	function automatic logic [31:0] irqToAddr(input logic [3:0] act);
		if (act[0]) begin
			irqToAddr = RUN_ADDR_IRQ0;
		end else if (act[1]) begin
			irqToAddr = RUN_ADDR_IRQ1;
		end else if (act[2]) begin
			irqToAddr = RUN_ADDR_IRQ2;
		end else begin
			irqToAddr = RUN_ADDR_IRQ3;
		end
	endfunction

	////////////////////////////////////////////////////////////////
	always_comb begin
		logic chipRst;
		logic [3:0] irqAct;
		chipRst = ~st.rstSync;
		irqAct = ~st.irqSync & st.irqEnabled;
		next_st = st;
		next_st.rstMeta = chipResetN; // [RL19]
		next_st.rstSync = st.rstMeta; // [RL19]
		next_st.irqMeta = externalInterruptLinesN; // [RL19]
		next_st.irqSync = st.irqMeta; // [RL19]
		next_st.fetchValid = 1'b0;
		next_st.extPortClkEn = ~st.ioReset; // [RL14]
		if (chipRst) begin
			// full chip reset, straps tracked while held
			next_st.state = S_HOLD; // [RL2] [RL17]
			next_st.count = '0;
			next_st.boot = rbc_boot_t'(bootMode);
			next_st.resetDone = 1'b0;
			next_st.ioReset = 1'b1; // [RL2]
			next_st.coreReset = 1'b1;
			next_st.coreIdle = 1'b0;
			next_st.fetchAddr = '0;
			next_st.irqEnabled = IRQ_EN_RESET; // [RL9]
		end else begin
			unique case (st.state)
				S_HOLD: begin
					next_st.state = S_PLL;
					next_st.count = '0;
				end
				S_PLL: begin
					next_st.count = st.count + 1'b1;
					if (st.count == LOCK_LAST) begin
						next_st.state = S_INIT; // [RL10]
						next_st.count = '0;
						next_st.ioReset = 1'b0;
					end
				end
				S_INIT: begin
					next_st.count = st.count + 1'b1;
					if (st.count == INIT_LAST) begin
						next_st.state = S_IDLE;
						next_st.resetDone = 1'b1; // [RL18]
						next_st.coreReset = 1'b0;
						next_st.coreIdle = 1'b1; // [RL8]
					end
				end
				S_IDLE: begin
					if (st.boot == BOOT_NONE && irqAct != 4'h0) begin
						next_st.state = S_RUN; // [RL6] [RL5]
						next_st.fetchAddr = irqToAddr(irqAct); // [RL7]
						next_st.fetchValid = 1'b1;
						next_st.coreIdle = 1'b0;
					end else if (st.boot != BOOT_NONE && bootStart) begin
						next_st.state = S_RUN; // [RL5]
						next_st.fetchAddr = RUN_ADDR_IRQ3;
						next_st.fetchValid = 1'b1;
						next_st.coreIdle = 1'b0;
					end
				end
				S_RUN: begin
				end
				S_CORE_RST: begin
					next_st.count = st.count + 1'b1;
					if (st.count == CORE_LAST && !coreSoftResetBit) begin
						next_st.state = S_IDLE; // [RL8]
						next_st.coreReset = 1'b0;
						next_st.coreIdle = 1'b1;
					end else if (st.count == CORE_LAST) begin
						next_st.count = st.count;
					end
				end
			endcase
			// core-only reset: io and reset-done untouched
			if (coreSoftResetBit && (st.state == S_IDLE || st.state == S_RUN)) begin
				next_st.state = S_CORE_RST; // [RL3]
				next_st.count = '0;
				next_st.coreReset = 1'b1; // [RL3]
				next_st.coreIdle = 1'b0;
				next_st.fetchValid = 1'b0;
				next_st.irqEnabled = IRQ_EN_RESET; // [RL9]
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '{rstMeta: 1'b0, rstSync: 1'b0, irqMeta: 4'hF, irqSync: 4'hF,
				state: S_HOLD, count: '0, boot: BOOT_MEMORY, resetDone: 1'b0,
				ioReset: 1'b1, coreReset: 1'b1, coreIdle: 1'b0, fetchAddr: '0,
				fetchValid: 1'b0, irqEnabled: IRQ_EN_RESET, extPortClkEn: 1'b0};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign cif.ratioStraps = coreRatioStraps;
	assign cif.trackStraps = ~st.rstSync; // [RL17]
	assign cif.linkDivisor = linkDivisor;

	assign resetDone = st.resetDone;
	assign ioReset = st.ioReset;
	assign coreReset = st.coreReset;
	assign coreIdle = st.coreIdle;
	assign fetchAddr = st.fetchAddr;
	assign fetchValid = st.fetchValid;
	assign irqEnabled = st.irqEnabled;
	assign extPortClkEn = st.extPortClkEn;
	assign pllMult = cif.pllMult;
	assign ratioBad = cif.ratioBad;
	assign linkClk = cif.linkClk;
	assign busTicks = cif.busTicks;
endmodule

/* File: dv/rbc_seq_chk.sv */
`timescale 1ns/100ps
module rbc_seq_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic chipResetN,
	input wire logic [3:0] externalInterruptLinesN,
	input wire logic [2:0] coreRatioStraps,
	input wire logic [1:0] bootMode,
	input wire logic bootStart,
	input wire logic coreSoftResetBit,
	input wire logic [rbc_pkg::LINK_DIV_W-1:0] linkDivisor,
	input wire logic resetDone,
	input wire logic ioReset,
	input wire logic coreReset,
	input wire logic coreIdle,
	input wire logic [31:0] fetchAddr,
	input wire logic fetchValid,
	input wire logic [3:0] irqEnabled,
	input wire logic [3:0] pllMult,
	input wire logic ratioBad,
	input wire logic linkClk,
	input wire logic [3:0] busTicks,
	input wire logic extPortClkEn
);
	import rbc_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	function automatic logic [3:0] multOf(input logic [2:0] c);
		case (c)
			3'h5: return 4'hA;
			3'h6: return 4'hC;
			3'h7: return 4'h4;
			default: return {1'b0, c} + 4'h4;
		endcase
	endfunction
	// lowest active line wins
	function automatic logic [31:0] addrOf(input logic [3:0] n);
		if (!n[0]) return 32'h3000_0000;
		if (!n[1]) return 32'h3800_0000;
		if (!n[2]) return 32'h8000_0000;
		return 32'h0000_0000;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	fetch_pulse_a: assert property (
		fetchValid |=> !fetchValid) else $error("fetch pulse longer than one cycle");
	wake_from_idle_a: assert property (
		fetchValid |-> $past(coreIdle)) else $error("fetch without idle core");
	start_addr_a: assert property (
		fetchValid && bootMode == 2'h3 |-> fetchAddr == addrOf($past(externalInterruptLinesN, 3)))
		else $error("wrong start address");
	done_order_a: assert property (
		resetDone |-> !ioReset && extPortClkEn) else $error("done while io held");
	ratio_map_a: assert property (
		resetDone && chipResetN |-> pllMult == multOf(coreRatioStraps)
		&& ratioBad == (coreRatioStraps == 3'h7)) else $error("wrong multiplier");
	chip_reset_a: assert property (
		$fell(chipResetN) |-> ##[2:6] (ioReset && coreReset && !resetDone))
		else $error("chip reset not applied");
	sync_delay_a: assert property (
		$fell(chipResetN) && resetDone |=> resetDone) else $error("reset pin not synchronised");
	core_only_a: assert property (
		coreSoftResetBit && resetDone && !coreReset |=> coreReset && resetDone && !ioReset)
		else $error("soft reset wrong scope");
	idle_exit_a: assert property (
		$fell(coreReset) |-> coreIdle && irqEnabled == 4'hF) else $error("core not idle after reset");
	bus_half_a: assert property (
		resetDone && $past(resetDone) && $stable(pllMult)
		|-> 5'(busTicks) + 5'($past(busTicks)) == 5'(pllMult)) else $error("bus rate not half");
	cover property (fetchValid && bootMode == 2'h3);
	cover property ($rose(coreReset) && resetDone);
	cover property (resetDone && ratioBad);
endmodule
bind rbc_sequencer rbc_seq_chk chk_u (.*);

/* File: dv/rbc_board_model.sv */
`timescale 1ns/100ps
module rbc_board_model (
	input wire logic sys_clk,
	input wire logic holdReset,
	input wire logic [2:0] strapReq,
	input wire logic irqReq,
	input wire logic [1:0] irqLine,
	input wire logic resetDone,
	output logic chipResetN,
	output logic [2:0] coreRatioStraps,
	output logic [3:0] externalInterruptLinesN,
	output logic dramPowerOk
);
	assign dramPowerOk = resetDone;
	// reset and irq pins settle on the first edge, straps on the second, while the bench still holds rst
	always @(posedge sys_clk) begin
		chipResetN <= !holdReset;
		if (!chipResetN) begin
			coreRatioStraps <= strapReq;
		end
		externalInterruptLinesN <= irqReq ? ~(4'h1 << irqLine) : 4'hF;
	end
endmodule

/* File: dv/test_reset_boot_clock_sequencer.sv */
`timescale 1ns/100ps
module test_reset_boot_clock_sequencer;
	import rbc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic holdReset = 1'b1;
	logic [2:0] strapReq = 3'h0;
	logic irqReq = 1'b0;
	logic [1:0] irqLine = 2'h0;
	logic [1:0] bootMode = 2'h3;
	logic bootStart = 1'b0;
	logic coreSoftResetBit = 1'b0;
	logic [LINK_DIV_W-1:0] linkDivisor = 8'h10;
	logic chipResetN, resetDone, ioReset, coreReset, coreIdle, fetchValid, ratioBad, linkClk;
	logic extPortClkEn;
	logic [2:0] coreRatioStraps;
	logic [3:0] externalInterruptLinesN, irqEnabled, pllMult, busTicks;
	logic [31:0] fetchAddr;
	logic [3:0] multTab [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'h4};
	logic [31:0] addrTab [4] = '{32'h3000_0000, 32'h3800_0000, 32'h8000_0000, 32'h0000_0000};
	int numErrors = 0;
	int nCompared = 0;
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	rbc_board_model board_u (.sys_clk(sys_clk), .holdReset(holdReset), .strapReq(strapReq),
		.irqReq(irqReq), .irqLine(irqLine), .resetDone(resetDone), .chipResetN(chipResetN),
		.coreRatioStraps(coreRatioStraps), .externalInterruptLinesN(externalInterruptLinesN),
		.dramPowerOk());
	rbc_sequencer #(.LOCK_CYC(3), .INIT_CYCLES(5), .CORE_CYC(2)) dut_u (.sys_clk(sys_clk),
		.rst(rst), .ce(1'b1), .chipResetN(chipResetN), .coreRatioStraps(coreRatioStraps),
		.externalInterruptLinesN(externalInterruptLinesN), .bootMode(bootMode),
		.bootStart(bootStart), .coreSoftResetBit(coreSoftResetBit), .linkDivisor(linkDivisor),
		.resetDone(resetDone), .ioReset(ioReset), .coreReset(coreReset), .coreIdle(coreIdle),
		.fetchAddr(fetchAddr), .fetchValid(fetchValid), .irqEnabled(irqEnabled),
		.pllMult(pllMult), .ratioBad(ratioBad), .linkClk(linkClk), .busTicks(busTicks),
		.extPortClkEn(extPortClkEn));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		nCompared++;
		if (got !== exp) begin
			numErrors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic reportAndStop();
		$display("compared %0d, mismatches %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return resetDone;
			1: return fetchValid;
			2: return coreReset;
			default: return coreIdle;
		endcase
	endfunction
	task automatic waitFor(input int s);
		int k;
		k = 0;
		// never look in the time step of a launching edge
		@(negedge sys_clk);
		while (pick(s) !== 1'b1) begin
			@(negedge sys_clk);
			k++;
			if (k > 400) begin
				numErrors++;
				reportAndStop();
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic bootSeq(input logic [2:0] code, input logic [1:0] mode);
		@(posedge sys_clk);
		holdReset <= 1'b1;
		strapReq <= code;
		bootMode <= mode;
		repeat (8) @(posedge sys_clk);
		holdReset <= 1'b0;
		@(negedge sys_clk);
		check("done before sequence", 32'h0, 32'(resetDone));
		waitFor(0);
		check("io reset", 32'h0, 32'(ioReset));
		check("idle after reset", 32'h1, 32'(coreIdle));
		check("irq enables", 32'hF, 32'(irqEnabled));
	endtask
	task automatic wakeIrq(input logic [1:0] line, input logic [31:0] addr);
		@(posedge sys_clk);
		irqLine <= line;
		irqReq <= 1'b1;
		waitFor(1);
		check("fetch address", addr, fetchAddr);
		check("core running", 32'h0, 32'(coreIdle));
		@(posedge sys_clk);
		irqReq <= 1'b0;
		@(negedge sys_clk);
		check("fetch pulse", 32'h0, 32'(fetchValid));
	endtask
	task automatic bootWake(input logic [1:0] mode);
		bootSeq(3'h1, mode);
		@(posedge sys_clk);
		irqReq <= 1'b1;
		repeat (8) @(negedge sys_clk);
		check("irq ignored", 32'h1, 32'(coreIdle));
		@(posedge sys_clk);
		irqReq <= 1'b0;
		bootStart <= 1'b1;
		waitFor(1);
		check("boot address", 32'h0, fetchAddr);
		@(posedge sys_clk);
		bootStart <= 1'b0;
	endtask
	task automatic softReset();
		@(posedge sys_clk);
		coreSoftResetBit <= 1'b1;
		waitFor(2);
		check("io kept", 32'h0, 32'(ioReset));
		check("done kept", 32'h1, 32'(resetDone));
		repeat (4) @(posedge sys_clk);
		coreSoftResetBit <= 1'b0;
		waitFor(3);
		check("core released", 32'h0, 32'(coreReset));
		wakeIrq(2'h2, 32'h8000_0000);
	endtask
	task automatic clockRates(input logic [2:0] code, input logic [7:0] div, input int expLink,
		input int expBus);
		int toggles;
		int ticks;
		logic prev;
		toggles = 0;
		ticks = 0;
		@(posedge sys_clk);
		linkDivisor <= div;
		bootSeq(code, 2'h3);
		prev = linkClk;
		repeat (120) begin
			@(negedge sys_clk);
			toggles += int'(linkClk != prev);
			prev = linkClk;
			ticks += int'(busTicks);
		end
		check("link toggles", 32'h1, 32'(toggles >= expLink - 1 && toggles <= expLink + 1));
		check("bus ticks", 32'(expBus), 32'(ticks));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			bootSeq(3'(i), 2'h3);
			check("multiplier", 32'(multTab[i]), 32'(pllMult));
			check("reserved code", 32'(i == 7), 32'(ratioBad));
			wakeIrq(2'(i), addrTab[i % 4]);
		end
		softReset();
		for (int m = 0; m < 3; m++) begin
			bootWake(2'(m));
		end
		clockRates(3'h0, 8'h10, 30, 240);
		clockRates(3'h0, 8'h05, 40, 240);
		clockRates(3'h1, 8'h0C, 50, 300);
		reportAndStop();
	end
endmodule
